// ==== hdl/port_pin_value_top.sv ====
// Purpose: 8-bit bidirectional port with bridge output mux and timer select
// Assumes: inputs synchronous to REF_CLK_I; software bits arrive as ports
// Notes:   host port logic itself lives elsewhere; only its enable is here
`timescale 1ns/1ps
module port_pin_value_top
    import port_pin_value_pkg::*;
#(
    parameter int WIDTH = PORT_WIDTH
) (
    // clock and reset
    input  wire logic             REF_CLK_I,
    input  wire logic             ARST_N_I,
    // software access
    input  wire logic [WIDTH-1:0] WDATA_I,
    input  wire logic             DIR_WR_I,
    input  wire logic             LATCH_WR_I,
    input  wire logic             DATA_WR_I,
    output logic      [WIDTH-1:0] DIR_RD_O,
    output logic      [WIDTH-1:0] LATCH_RD_O,
    output logic      [WIDTH-1:0] PIN_RD_O,
    input  wire logic [7:0]       E_DIR_I,
    // unit control
    input  wire logic [1:0]       PWM_CFG_I,
    input  wire logic [3:0]       UNIT_MODE_I,
    input  wire logic [3:0]       BRIDGE_I,
    input  wire logic             SPECIAL_TRIG_I,
    // pins
    input  wire logic [WIDTH-1:0] PIN_I,
    output logic      [WIDTH-1:0] PIN_O,
    output logic      [WIDTH-1:0] PIN_OE_O,
    output logic                  C2_O,
    output logic                  C2_OE_O,
    // status
    output logic                  HOST_PORT_EN_O,
    output logic                  TIMER_ONE_SEL_O,
    output logic                  TIMER_TWO_SEL_O,
    output logic                  TIMER_ONE_CLR_O
);
    typedef struct packed {
        logic [WIDTH-1:0] dir;
        logic [WIDTH-1:0] latch;
        logic [WIDTH-1:0] pins;
        logic [WIDTH-1:0] pin_o;
        logic [WIDTH-1:0] pin_oe;
        logic             c2;
        logic             c2_oe;
        logic             host_en;
        timebase_t        tb;
        logic             t1_clr;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    port_pin_value_if lanes ();

    bridge_decode u_dec (
        .cfg_i  (PWM_CFG_I),
        .mode_i (UNIT_MODE_I),
        .lanes  (lanes)
    );

    logic [WIDTH-1:0] pwm_own;
    logic [WIDTH-1:0] pwm_val;

    always_comb begin
        pwm_own        = '0;
        pwm_val        = '0;
        pwm_own[BIT_B] = lanes.lane_active[1];
        pwm_own[BIT_C] = lanes.lane_active[2];
        pwm_own[BIT_D] = lanes.lane_active[3];
        pwm_val[BIT_B] = BRIDGE_I[1];
        pwm_val[BIT_C] = BRIDGE_I[2];
        pwm_val[BIT_D] = BRIDGE_I[3];
    end

    always_comb begin
        st_nxt = st_r;
        if (DIR_WR_I) begin
            st_nxt.dir = WDATA_I;
        end
        // both write paths land in the latch
        if (LATCH_WR_I || DATA_WR_I) begin
            st_nxt.latch = WDATA_I;
        end
        st_nxt.pins = PIN_I;
        // pwm needs cleared direction bits to reach the pin
        for (int i = 0; i < WIDTH; i++) begin
            st_nxt.pin_oe[i] = ~st_nxt.dir[i];
            st_nxt.pin_o[i]  = pwm_own[i] ? pwm_val[i] : st_nxt.latch[i];
        end
        st_nxt.c2      = BRIDGE_I[0];
        st_nxt.c2_oe   = lanes.lane_active[0];
        // multi-output pwm wins over the host port select
        st_nxt.host_en = E_DIR_I[HOST_SEL_BIT] & ~lanes.multi_out;
        if (lanes.pwm_mode) begin
            st_nxt.tb = TB_TIMER_TWO;
        end else if (UNIT_MODE_I != MODE_OFF) begin
            st_nxt.tb = TB_TIMER_ONE;
        end else begin
            st_nxt.tb = TB_NONE;
        end
        st_nxt.t1_clr = SPECIAL_TRIG_I && (st_nxt.tb == TB_TIMER_ONE);
    end

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            st_r         <= '0;
            st_r.dir     <= DIR_RESET;
            st_r.latch   <= LATCH_RESET;
            st_r.pins    <= PIN_RESET;
            st_r.tb      <= TB_NONE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign DIR_RD_O        = st_r.dir;
    assign LATCH_RD_O      = st_r.latch;
    assign PIN_RD_O        = st_r.pins;
    assign PIN_O           = st_r.pin_o;
    assign PIN_OE_O        = st_r.pin_oe;
    assign C2_O            = st_r.c2;
    assign C2_OE_O         = st_r.c2_oe;
    assign HOST_PORT_EN_O  = st_r.host_en;
    assign TIMER_ONE_SEL_O = (st_r.tb == TB_TIMER_ONE);
    assign TIMER_TWO_SEL_O = (st_r.tb == TB_TIMER_TWO);
    assign TIMER_ONE_CLR_O = st_r.t1_clr;
endmodule : port_pin_value_top

// ==== hdl/port_pin_value_pkg.sv ====
// Purpose: shared constants and types for the port with bridge output mux
// Assumes: one clock, no register bus
// Notes:   mode field encodings follow the unit control field layout
package port_pin_value_pkg;
    localparam int          PORT_WIDTH      = 8;
    localparam logic [7:0]  DIR_RESET       = 8'hFF;
    localparam logic [7:0]  LATCH_RESET     = 8'h00;
    localparam logic [7:0]  PIN_RESET       = 8'h00;
    localparam int          HOST_SEL_BIT    = 4;
    localparam int          BIT_B           = 5;
    localparam int          BIT_C           = 6;
    localparam int          BIT_D           = 7;
    localparam logic [3:0]  MODE_OFF        = 4'h0;
    localparam logic [1:0]  PWM_MODE_TOP    = 2'h3;
    localparam logic [1:0]  CFG_SINGLE      = 2'h0;
    localparam logic [1:0]  CFG_DUAL        = 2'h2;
    localparam logic [15:0] TIMER_CLEAR     = 16'h0000;

    typedef enum logic [1:0] {
        TB_NONE,
        TB_TIMER_ONE,
        TB_TIMER_TWO
    } timebase_t;
endpackage : port_pin_value_pkg

// ==== hdl/port_pin_value_if.sv ====
// Purpose: carries pwm lane assignment from decoder to port
// Assumes: one clock domain
// Notes:   purely combinational signals
`timescale 1ns/1ps
interface port_pin_value_if;
    logic [3:0] lane_active;
    logic       multi_out;
    logic       pwm_mode;
    modport dec  (output lane_active, output multi_out, output pwm_mode);
    modport port (input lane_active, input multi_out, input pwm_mode);
endinterface : port_pin_value_if

// ==== hdl/bridge_decode.sv ====
// Purpose: decode unit mode and output config into active bridge lanes
// Assumes: mode fields are software-held levels
// Notes:   lane 0 is output a on the c-port bit 2
`timescale 1ns/1ps
module bridge_decode
    import port_pin_value_pkg::*;
(
    input  wire logic [1:0] cfg_i,
    input  wire logic [3:0] mode_i,
    port_pin_value_if.dec            lanes
);
    always_comb begin
        lanes.pwm_mode    = (mode_i[3:2] == PWM_MODE_TOP);
        lanes.lane_active = 4'h0;
        lanes.multi_out   = 1'b0;
        if (lanes.pwm_mode) begin
            lanes.lane_active[0] = 1'b1;
            if (cfg_i[0]) begin
                lanes.lane_active = 4'hF;
                lanes.multi_out   = 1'b1;
            end else if (cfg_i == CFG_DUAL) begin
                lanes.lane_active = 4'h3;
                lanes.multi_out   = 1'b1;
            end
        end
    end
endmodule : bridge_decode

// ==== tb/port_pin_value_asserts.sv ====
// Purpose: timing checks on the port outputs
// Assumes: outputs registered one cycle after inputs
// Notes:   lane checks look at drive value, not the wire
`timescale 1ns/1ps
module port_pin_value_asserts
    import port_pin_value_pkg::*;
(
    input wire logic       REF_CLK_I, ARST_N_I, DIR_WR_I, LATCH_WR_I, DATA_WR_I, SPECIAL_TRIG_I,
    input wire logic [7:0] WDATA_I, DIR_RD_O, LATCH_RD_O, PIN_RD_O, PIN_I, PIN_O, PIN_OE_O, E_DIR_I,
    input wire logic [1:0] PWM_CFG_I,
    input wire logic [3:0] UNIT_MODE_I, BRIDGE_I,
    input wire logic       C2_O, C2_OE_O, HOST_PORT_EN_O, TIMER_ONE_SEL_O, TIMER_TWO_SEL_O, TIMER_ONE_CLR_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!ARST_N_I);
    wire pwm   = UNIT_MODE_I[3:2] == PWM_MODE_TOP;
    wire multi = pwm && PWM_CFG_I != CFG_SINGLE;
    wire cmp   = UNIT_MODE_I != MODE_OFF && !pwm;
    sequence quad_req; pwm && PWM_CFG_I[0]; endsequence
    sequence lane_out; PIN_O[7:5] == $past(BRIDGE_I[3:1]); endsequence
    dir_load_a: assert property (DIR_WR_I |=> DIR_RD_O == $past(WDATA_I)) else $error("dir");
    latch_load_a: assert property (LATCH_WR_I || DATA_WR_I |=> LATCH_RD_O == $past(WDATA_I)) else $error("latch");
    oe_dir_a: assert property (PIN_OE_O == ~DIR_RD_O) else $error("oe");
    pin_sample_a: assert property ($past(ARST_N_I) |-> PIN_RD_O == $past(PIN_I)) else $error("sample");
    quad_lane_a: assert property (quad_req |=> lane_out) else $error("quad");
    single_pin_a: assert property (!multi |=> PIN_O == LATCH_RD_O) else $error("single");
    c2_lane_a: assert property (pwm |=> C2_OE_O && C2_O == $past(BRIDGE_I[0])) else $error("c2");
    host_off_a: assert property (multi |=> !HOST_PORT_EN_O) else $error("host off");
    host_on_a: assert property (E_DIR_I[HOST_SEL_BIT] && !multi |=> HOST_PORT_EN_O) else $error("host");
    timer_sel_a: assert property ($past(ARST_N_I) |-> TIMER_TWO_SEL_O == $past(pwm)) else $error("tsel");
    trig_clr_a: assert property (SPECIAL_TRIG_I && cmp |=> TIMER_ONE_CLR_O) else $error("clr");
endmodule : port_pin_value_asserts
bind port_pin_value_top port_pin_value_asserts i_port_pin_value_asserts (.*);

// ==== tb/pin_partner.sv ====
// Purpose: external circuit on the eight pins
// Assumes: no pull resistors
// Notes:   released pins show a fresh bench level each step
`timescale 1ns/1ps
module pin_partner (
    // pin side
    input  wire logic [7:0] drv_i,
    input  wire logic [7:0] en_i,
    input  wire logic [7:0] ext_i,
    output logic      [7:0] pin_o
);
    assign pin_o = (en_i & drv_i) | (~en_i & ext_i);
endmodule : pin_partner

// ==== tb/tb_top.sv ====
// Purpose: random steps with queued expectations
// Assumes: each step settles within three cycles
// Notes:   dir bits random, so lanes may sit on inputs
`timescale 1ns/1ps
module tb_top;
    import port_pin_value_pkg::*;
    logic        clk = 0, rst_n = 0, dwr = 0, lwr = 0, dat = 0, trig = 0, v1 = 0, v2 = 0;
    logic [7:0]  wd = 0, edir = 0, ext = 0, pin, dir_rd, lat_rd, pin_rd, po, poe;
    logic [1:0]  cfg = 0;
    logic [3:0]  mode = 0, br = 0;
    logic        c2, c2oe, host, t1, t2;
    logic        t1c;
    logic [45:0] q[$];
    logic [31:0] rs = 32'h00009AB1;
    int          n_mismatch = 0, total_checks = 0, cyc = 0;
    port_pin_value_top i_port_pin_value_top (.REF_CLK_I(clk), .ARST_N_I(rst_n), .WDATA_I(wd), .DIR_WR_I(dwr), .LATCH_WR_I(lwr),
        .DATA_WR_I(dat), .DIR_RD_O(dir_rd), .LATCH_RD_O(lat_rd), .PIN_RD_O(pin_rd), .E_DIR_I(edir),
        .PWM_CFG_I(cfg), .UNIT_MODE_I(mode), .BRIDGE_I(br), .SPECIAL_TRIG_I(trig), .PIN_I(pin), .PIN_O(po),
        .PIN_OE_O(poe), .C2_O(c2), .C2_OE_O(c2oe), .HOST_PORT_EN_O(host), .TIMER_ONE_SEL_O(t1),
        .TIMER_TWO_SEL_O(t2), .TIMER_ONE_CLR_O(t1c));
    pin_partner i_pin_partner (.drv_i(po), .en_i(poe), .ext_i(ext), .pin_o(pin));
    function automatic logic [31:0] xs;
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : xs
    task automatic check(input logic [45:0] seen, input logic [45:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    // dir write, then latch or data write; lanes replace latch bits
    task automatic step(input logic sel);
        logic [31:0] r;
        logic [7:0]  d, l, o;
        logic        p, m;
        r = xs();
        d = xs();
        l = xs();
        p = r[3:2] == PWM_MODE_TOP;
        m = p && r[5:4] != CFG_SINGLE;
        o = l;
        if (m) o[BIT_B] = r[7];
        if (p && r[4]) o[BIT_D:BIT_C] = r[9:8];
        // pwm reaches a pin only where the random direction bit is cleared
        q.push_back({d, l, o, ~d, (~d & o) | (d & r[25:18]), p, p & r[6], r[14] & !m, r[3:0] != MODE_OFF && !p, p,
                     r[26] && r[3:0] != MODE_OFF && !p});
        @(posedge clk);
        {trig, ext, edir, br, cfg, mode} <= r[26:0];
        wd <= d;
        dwr <= 1'h1;
        @(posedge clk);
        dwr <= 1'h0;
        wd <= l;
        {dat, lwr} <= sel ? 2'h2 : 2'h1;
        @(posedge clk);
        {dat, lwr} <= 2'h0;
    endtask : step
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        v1 <= lwr | dat;
        v2 <= v1;
        cyc <= cyc + 1;
        if (v2) check({dir_rd, lat_rd, po, poe, pin_rd, c2oe, c2 & c2oe, host, t1, t2, t1c}, q.pop_front());
        if (cyc == 800) begin
            n_mismatch++;
            conclude();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'h1;
        @(negedge clk);
        check({22'h0, dir_rd, lat_rd, poe}, {22'h0, DIR_RESET, LATCH_RESET, 8'h00});
        $display("reset test done");
        for (int i = 0; i < 60; i++) step(i[0]);
        repeat (4) @(posedge clk);
        $display("random test done");
        conclude();
    end
endmodule : tb_top
